// ### logic/hrpl_params.svh
// constants for the high-register / pc-relative load executor
// assumes 16-bit instruction words and a 32-bit datapath
// How it works
// - destination index is bits 2:0, source 5:3, bit 6 adds 8 to source, bit 7 to destination.
// - opcode 00 adds source to destination and writes the sum to the destination.
// - only compare (01) updates the flags, from destination minus source.
// - opcode 10 with a high flag set copies source to destination, flags kept.
// - add, compare or move with both high flags clear has no defined result.
// - branch-exchange jumps to the source value; its bit 0 picks 32-bit (0) or 16-bit (1) state.
// - branch-exchange with the destination high flag set has no defined result.
// - register 15 read as an operand gives instruction address plus 4 with bit 0 cleared.
// - the pc-relative load adds up to 255 words to the pc and loads that word into the destination.
// - the 8-bit offset field is scaled by four into a word-aligned 10-bit byte offset.
// - the load base is instruction address plus 4 with bit 1 cleared.
// - each instruction takes as many cycles as its 32-bit-state equivalent.
`ifndef HRPL_PARAMS_SVH
`define HRPL_PARAMS_SVH
`define HRPL_FMT5_TAG 6'h11
`define HRPL_FMT6_TAG 5'h09
`define HRPL_TAG5_HI 15
`define HRPL_TAG5_LO 10
`define HRPL_TAG6_LO 11
`define HRPL_OP_HI 9
`define HRPL_OP_LO 8
`define HRPL_DST_HFLAG 7
`define HRPL_SRC_HFLAG 6
`define HRPL_SRC_HI 5
`define HRPL_SRC_LO 3
`define HRPL_DST_HI 2
`define HRPL_DST_LO 0
`define HRPL_LDR_DST_HI 10
`define HRPL_LDR_DST_LO 8
`define HRPL_OFF_HI 7
`define HRPL_OP_ADD 2'h0
`define HRPL_OP_CMP 2'h1
`define HRPL_OP_MOV 2'h2
`define HRPL_OP_BX 2'h3
`define HRPL_PC_IDX 4'hf
`define HRPL_PC_AHEAD 32'h4
`define HRPL_CLR_BIT0 32'hffff_fffe
`define HRPL_CLR_BIT1 32'hffff_fffd
`define HRPL_FLAG_N 3
`define HRPL_FLAG_Z 2
`define HRPL_FLAG_C 1
`define HRPL_FLAG_V 0
`define HRPL_LONG_CYC 2'h3
`endif

// ### logic/hrpl_pkg.sv
// types shared by the decoder and the executor
// no assumptions beyond a single clock domain
package hrpl_pkg;
	typedef enum logic [2:0] {
		KIND_NONE = 3'b000,
		KIND_ADD = 3'b001,
		KIND_CMP = 3'b010,
		KIND_MOV = 3'b011,
		KIND_BX = 3'b100,
		KIND_LDR = 3'b101
	} hrpl_kind_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HOLD = 2'b01,
		ST_LOAD_REQ = 2'b10,
		ST_LOAD_FIN = 2'b11
	} hrpl_state_type;
endpackage : hrpl_pkg

// ### logic/hrpl_dec_if.sv
// decoded instruction fields passed from decoder to executor
// both ends run on the core clock; fields are combinational
`timescale 1ns/1ps
interface hrpl_dec_if;
	logic [15:0] instr;
	hrpl_pkg::hrpl_kind_type kind;
	logic [3:0] dest_idx;
	logic [3:0] src_idx;
	logic [7:0] word_off;
	logic undef;
	logic long_op;
	modport dec (input instr, output kind, dest_idx, src_idx, word_off,
		undef, long_op);
	modport exec (output instr, input kind, dest_idx, src_idx, word_off,
		undef, long_op);
endinterface : hrpl_dec_if

// ### logic/hrpl_decode.sv
// combinational decoder for the two instruction formats
// assumes the instruction word is stable while it is offered
`timescale 1ns/1ps
`include "hrpl_params.svh"
module hrpl_decode (
	hrpl_dec_if.dec bus
);
	logic fmt5;
	logic fmt6;
	logic [1:0] op;
	logic dst_high;
	logic src_high;

	// format match and field split
	assign fmt5 = bus.instr[`HRPL_TAG5_HI:`HRPL_TAG5_LO] == `HRPL_FMT5_TAG;
	assign fmt6 = bus.instr[`HRPL_TAG5_HI:`HRPL_TAG6_LO] == `HRPL_FMT6_TAG;
	assign op = bus.instr[`HRPL_OP_HI:`HRPL_OP_LO];
	assign dst_high = bus.instr[`HRPL_DST_HFLAG];
	assign src_high = bus.instr[`HRPL_SRC_HFLAG];
	assign bus.dest_idx = fmt6 ?
		{1'b0, bus.instr[`HRPL_LDR_DST_HI:`HRPL_LDR_DST_LO]} :
		{dst_high, bus.instr[`HRPL_DST_HI:`HRPL_DST_LO]};
	assign bus.src_idx = {src_high, bus.instr[`HRPL_SRC_HI:`HRPL_SRC_LO]};
	assign bus.word_off = bus.instr[`HRPL_OFF_HI:0];

	always_comb
	begin
		bus.kind = hrpl_pkg::KIND_NONE;
		if (fmt6)
			bus.kind = hrpl_pkg::KIND_LDR;
		else if (fmt5)
		begin
			case (op)
				`HRPL_OP_ADD: bus.kind = hrpl_pkg::KIND_ADD;
				`HRPL_OP_CMP: bus.kind = hrpl_pkg::KIND_CMP;
				`HRPL_OP_MOV: bus.kind = hrpl_pkg::KIND_MOV;
				default: bus.kind = hrpl_pkg::KIND_BX;
			endcase
		end
	end

	assign bus.undef = fmt5 && ((op != `HRPL_OP_BX && !dst_high && !src_high)
		|| (op == `HRPL_OP_BX && dst_high));
	// pc writes and branches refill the pipe: three cycles
	assign bus.long_op = (bus.kind == hrpl_pkg::KIND_BX) ||
		((bus.kind == hrpl_pkg::KIND_ADD || bus.kind == hrpl_pkg::KIND_MOV)
		&& bus.dest_idx == `HRPL_PC_IDX);
endmodule : hrpl_decode

// ### logic/hrpl_exec.sv
// executor for high-register ops, branch-exchange and pc-relative load
// assumes register file reads are combinational on the same clock and
// that the pipeline forwards results; one instruction in flight at a time
`timescale 1ns/1ps
`include "hrpl_params.svh"
module hrpl_exec (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic [15:0] instr,
	input wire logic [31:0] instr_addr,
	output logic [3:0] rd_a_idx,
	input wire logic [31:0] rd_a_data,
	output logic [3:0] rd_b_idx,
	input wire logic [31:0] rd_b_data,
	output logic wr_en,
	output logic [3:0] wr_idx,
	output logic [31:0] wr_data,
	input wire logic [3:0] current_status_flags,
	output logic flags_we,
	output logic [3:0] flags_out,
	output logic branch_valid,
	output logic [31:0] branch_target,
	output logic branch_narrow,
	output logic mem_req,
	output logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic undef_pulse,
	output logic done
);
	hrpl_dec_if dec_bus ();
	hrpl_pkg::hrpl_state_type state_q;
	hrpl_pkg::hrpl_kind_type kind_q;
	logic [1:0] cnt_q;
	logic accept;
	logic good;
	logic [31:0] pc_read;
	logic [31:0] a_val;
	logic [31:0] b_val;
	logic [31:0] sum;
	logic [32:0] diff;
	logic [31:0] ldr_base;
	logic [31:0] ldr_addr;
	logic [3:0] ldr_dst_q;
	logic [31:0] ld_data_q;
	logic wr_en_q;
	logic [3:0] wr_idx_q;
	logic [31:0] wr_data_q;
	logic flags_we_q;
	logic [3:0] flags_q;
	logic branch_valid_q;
	logic [31:0] branch_target_q;
	logic branch_narrow_q;
	logic mem_req_q;
	logic [31:0] mem_addr_q;
	logic undef_q;
	logic done_q;

	hrpl_decode u_dec (
		.bus(dec_bus)
	);

	// operand selection; reads go straight to the register file
	assign dec_bus.instr = instr;
	assign rd_a_idx = dec_bus.dest_idx;
	assign rd_b_idx = dec_bus.src_idx;
	// pc reads as address plus 4
	assign pc_read = (instr_addr + `HRPL_PC_AHEAD) & `HRPL_CLR_BIT0;
	assign a_val = (dec_bus.dest_idx == `HRPL_PC_IDX) ? pc_read : rd_a_data;
	assign b_val = (dec_bus.src_idx == `HRPL_PC_IDX) ? pc_read : rd_b_data;
	assign sum = a_val + b_val;
	assign diff = {1'b0, a_val} - {1'b0, b_val};
	assign ldr_base = (instr_addr + `HRPL_PC_AHEAD) & `HRPL_CLR_BIT1;
	assign ldr_addr = ldr_base + {22'h0, dec_bus.word_off, 2'b00};

	// handshake: only idle takes a new instruction
	assign instr_ready = state_q == hrpl_pkg::ST_IDLE;
	assign accept = instr_valid && instr_ready;
	assign good = accept && dec_bus.kind != hrpl_pkg::KIND_NONE &&
		!dec_bus.undef;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_q <= hrpl_pkg::ST_IDLE;
			cnt_q <= 2'h0;
		end
		else
		begin
			case (state_q)
				hrpl_pkg::ST_IDLE:
				begin
					if (good && dec_bus.kind == hrpl_pkg::KIND_LDR)
						state_q <= hrpl_pkg::ST_LOAD_REQ;
					else if (good && dec_bus.long_op)
					begin
						state_q <= hrpl_pkg::ST_HOLD;
						cnt_q <= `HRPL_LONG_CYC - 2'h2;
					end
				end
				hrpl_pkg::ST_HOLD:
				begin
					if (cnt_q == 2'h0)
						state_q <= hrpl_pkg::ST_IDLE;
					else
						cnt_q <= cnt_q - 2'h1;
				end
				hrpl_pkg::ST_LOAD_REQ:
				begin
					// wait as long as memory needs
					if (mem_ack)
						state_q <= hrpl_pkg::ST_LOAD_FIN;
				end
				hrpl_pkg::ST_LOAD_FIN: state_q <= hrpl_pkg::ST_IDLE;
				default: state_q <= hrpl_pkg::ST_IDLE;
			endcase
		end
	end

	// completion pulse; undefined codes also complete in one cycle
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			done_q <= 1'b0;
		else
			done_q <= (accept && dec_bus.kind != hrpl_pkg::KIND_NONE &&
				!(good && (dec_bus.long_op ||
				dec_bus.kind == hrpl_pkg::KIND_LDR))) ||
				(state_q == hrpl_pkg::ST_HOLD && cnt_q == 2'h0) ||
				state_q == hrpl_pkg::ST_LOAD_FIN;
	end

	// undefined codes do nothing but flag
	// undefined branch flagged the same way
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			undef_q <= 1'b0;
		else
			undef_q <= accept && dec_bus.undef;
	end

	// kind of the last accepted instruction, for checking
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			kind_q <= hrpl_pkg::KIND_NONE;
		else if (accept)
			kind_q <= dec_bus.kind;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wr_en_q <= 1'b0;
			wr_idx_q <= 4'h0;
			wr_data_q <= 32'h0;
		end
		else if (good && dec_bus.kind == hrpl_pkg::KIND_ADD)
		begin
			wr_en_q <= 1'b1;
			wr_idx_q <= dec_bus.dest_idx;
			wr_data_q <= sum;
		end
		else if (good && dec_bus.kind == hrpl_pkg::KIND_MOV)
		begin
			wr_en_q <= 1'b1;
			wr_idx_q <= dec_bus.dest_idx;
			wr_data_q <= b_val;
		end
		else if (state_q == hrpl_pkg::ST_LOAD_FIN)
		begin
			wr_en_q <= 1'b1;
			wr_idx_q <= ldr_dst_q;
			wr_data_q <= ld_data_q;
		end
		else
			wr_en_q <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			flags_we_q <= 1'b0;
			flags_q <= 4'h0;
		end
		else
		begin
			flags_we_q <= good && dec_bus.kind == hrpl_pkg::KIND_CMP;
			if (good && dec_bus.kind == hrpl_pkg::KIND_CMP)
			begin
				flags_q <= current_status_flags;
				flags_q[`HRPL_FLAG_N] <= diff[31];
				flags_q[`HRPL_FLAG_Z] <= diff[31:0] == 32'h0;
				flags_q[`HRPL_FLAG_C] <= !diff[32]; // carry = no borrow
				flags_q[`HRPL_FLAG_V] <= (a_val[31] != b_val[31]) &&
					(diff[31] != a_val[31]);
			end
		end
	end

	// branch target and state from bit 0
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			branch_valid_q <= 1'b0;
			branch_target_q <= 32'h0;
			branch_narrow_q <= 1'b0;
		end
		else
		begin
			branch_valid_q <= good && dec_bus.kind == hrpl_pkg::KIND_BX;
			if (good && dec_bus.kind == hrpl_pkg::KIND_BX)
			begin
				branch_target_q <= b_val & `HRPL_CLR_BIT0;
				branch_narrow_q <= b_val[0];
			end
		end
	end

	// load request held until memory acknowledges
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			mem_req_q <= 1'b0;
			mem_addr_q <= 32'h0;
			ldr_dst_q <= 4'h0;
			ld_data_q <= 32'h0;
		end
		else if (good && dec_bus.kind == hrpl_pkg::KIND_LDR)
		begin
			mem_req_q <= 1'b1;
			mem_addr_q <= ldr_addr;
			ldr_dst_q <= dec_bus.dest_idx;
		end
		else if (state_q == hrpl_pkg::ST_LOAD_REQ && mem_ack)
		begin
			mem_req_q <= 1'b0;
			ld_data_q <= mem_rdata;
		end
	end

	assign wr_en = wr_en_q;
	assign wr_idx = wr_idx_q;
	assign wr_data = wr_data_q;
	assign flags_we = flags_we_q;
	assign flags_out = flags_q;
	assign branch_valid = branch_valid_q;
	assign branch_target = branch_target_q;
	assign branch_narrow = branch_narrow_q;
	assign mem_req = mem_req_q;
	assign mem_addr = mem_addr_q;
	assign undef_pulse = undef_q;
	assign done = done_q;

	default clocking chk_cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	chk_add_sum: assert property (
		good && dec_bus.kind == hrpl_pkg::KIND_ADD |=>
		wr_en && wr_data == $past(a_val) + $past(b_val))
		else $error("add result wrong");
	chk_flags_cmp_only: assert property (
		flags_we |-> kind_q == hrpl_pkg::KIND_CMP)
		else $error("flags written by non-compare");
	chk_cmp_zero: assert property (
		good && dec_bus.kind == hrpl_pkg::KIND_CMP |=>
		flags_we && flags_out[`HRPL_FLAG_Z] == ($past(a_val) == $past(b_val)))
		else $error("compare zero flag wrong");
	chk_mov_copy: assert property (
		good && dec_bus.kind == hrpl_pkg::KIND_MOV |=>
		wr_en && wr_data == $past(b_val) && !flags_we)
		else $error("move result wrong");
	chk_undef_quiet: assert property (
		undef_pulse |-> !wr_en && !flags_we && !branch_valid && !mem_req)
		else $error("undefined code had an effect");
	chk_bx_state: assert property (
		good && dec_bus.kind == hrpl_pkg::KIND_BX |=>
		branch_valid && branch_narrow == $past(b_val[0]))
		else $error("branch state bit wrong");
	chk_pc_operand: assert property (
		accept && dec_bus.src_idx == `HRPL_PC_IDX |->
		b_val == ((instr_addr + 32'h4) & 32'hffff_fffe))
		else $error("pc operand wrong");
	chk_ldr_addr: assert property (
		good && dec_bus.kind == hrpl_pkg::KIND_LDR |=> mem_req &&
		mem_addr == (($past(instr_addr) + 32'h4) & 32'hffff_fffd) +
		{22'h0, $past(instr[7:0]), 2'b00})
		else $error("load address wrong");
	chk_ldr_cycles: assert property (
		good && dec_bus.kind == hrpl_pkg::KIND_LDR ##1 mem_ack |=>
		!done ##1 done && wr_en)
		else $error("load length wrong");
	chk_long_cycles: assert property (
		good && dec_bus.long_op |=> !done ##1 !done ##1 done)
		else $error("three-cycle length wrong");
	chk_short_cycles: assert property (
		good && !dec_bus.long_op && dec_bus.kind != hrpl_pkg::KIND_LDR
		|=> done && instr_ready)
		else $error("one-cycle length wrong");
	cov_add: cover property (wr_en && kind_q == hrpl_pkg::KIND_ADD);
	cov_cmp: cover property (flags_we);
	cov_bx_narrow: cover property (branch_valid && branch_narrow);
	cov_load: cover property (done && kind_q == hrpl_pkg::KIND_LDR);
endmodule : hrpl_exec

// ### tb/hrpl_core_model.sv
// stand-in for the core: register file read ports and memory load port
// assumes combinational register reads and one clock shared with the block
`timescale 1ns/1ps
module hrpl_core_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] rd_a_idx,
	output logic [31:0] rd_a_data,
	input wire logic [3:0] rd_b_idx,
	output logic [31:0] rd_b_data,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	input wire logic [3:0] ack_wait
);
	logic [3:0] wait_q;
	logic [31:0] junk_q;

	// register i holds its index in every nibble; r15 gives junk so the
	// block has to put in the pc value itself
	assign rd_a_data = (rd_a_idx == 4'hf) ? junk_q : {8{rd_a_idx}};
	assign rd_b_data = (rd_b_idx == 4'hf) ? ~junk_q : {8{rd_b_idx}};

	// ack after ack_wait cycles of request; data only valid with ack
	assign mem_ack = mem_req && (wait_q == ack_wait);
	assign mem_rdata = mem_ack ? (mem_addr ^ 32'ha5a5_a5a5) : junk_q;

	// changing pattern so stale read data never matches by luck
	always_ff @(posedge ref_clk)
	begin
		junk_q <= rst ? 32'h5a5a_0ff0 : ~junk_q;
		wait_q <= (rst || !mem_req || mem_ack) ? 4'h0 : wait_q + 4'h1;
	end
endmodule : hrpl_core_model

// ### tb/tb_hrpl_exec.sv
// self-checking bench for the high-register / pc-relative load executor
// assumes the core model above as register file and memory
`timescale 1ns/1ps
module tb_hrpl_exec;
	typedef struct packed {
		logic wr;
		logic [3:0] widx;
		logic [31:0] wdata;
		logic fl;
		logic [3:0] flags;
		logic br;
		logic [31:0] tgt;
		logic nar;
		logic und;
		logic [31:0] ma;
		logic [4:0] cyc;
	} hrpl_res_type;
	typedef struct {
		logic [15:0] ins;
		logic [31:0] adr;
		hrpl_res_type e;
	} hrpl_row_type;
	localparam logic [31:0] adr0 = 32'h0000_1002;
	localparam logic [31:0] pcv = (adr0 + 32'h4) & ~32'h1;
	logic ref_clk = 1'b0;
	logic rst, instr_valid, instr_ready, wr_en, flags_we, branch_valid;
	logic branch_narrow, mem_req, mem_ack, undef_pulse, done;
	logic [15:0] instr;
	logic [31:0] instr_addr, rd_a_data, rd_b_data, wr_data, branch_target;
	logic [31:0] mem_addr, mem_rdata;
	logic [3:0] rd_a_idx, rd_b_idx, wr_idx, current_status_flags;
	logic [3:0] flags_out, ack_wait;
	int fail_count = 0;
	int checked = 0;
	hrpl_row_type rows[$];
	hrpl_res_type g;
	// words that must only raise the undefined pulse
	logic [15:0] und_words [4] = '{16'h4412, 16'h4512, 16'h4612, 16'h4788};

	// 200 MHz core clock
	always #2.5 ref_clk = ~ref_clk;

	hrpl_exec dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
		.instr_ready(instr_ready), .instr(instr), .instr_addr(instr_addr),
		.rd_a_idx(rd_a_idx), .rd_a_data(rd_a_data), .rd_b_idx(rd_b_idx),
		.rd_b_data(rd_b_data), .wr_en(wr_en), .wr_idx(wr_idx),
		.wr_data(wr_data), .current_status_flags(current_status_flags),
		.flags_we(flags_we), .flags_out(flags_out),
		.branch_valid(branch_valid), .branch_target(branch_target),
		.branch_narrow(branch_narrow), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.undef_pulse(undef_pulse), .done(done));
	hrpl_core_model core (.ref_clk(ref_clk), .rst(rst), .rd_a_idx(rd_a_idx),
		.rd_a_data(rd_a_data), .rd_b_idx(rd_b_idx), .rd_b_data(rd_b_data),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .ack_wait(ack_wait));

	function automatic logic [31:0] rv(input logic [3:0] i);
		return {8{i}};
	endfunction : rv

	// load base: pc ahead by four, bit 1 dropped
	function automatic logic [31:0] lb(input logic [31:0] a);
		return (a + 32'h4) & ~32'h2;
	endfunction : lb

	function automatic hrpl_res_type ew(input logic [3:0] i,
		input logic [31:0] d, input logic [4:0] c);
		hrpl_res_type r;
		r = '0;
		r.wr = 1'b1;
		r.widx = i;
		r.wdata = d;
		r.cyc = c;
		return r;
	endfunction : ew

	// nzcv of a minus b; carry means no borrow
	function automatic hrpl_res_type ef(input logic [31:0] a,
		input logic [31:0] b);
		hrpl_res_type r;
		logic [31:0] d;
		d = a - b;
		r = '0;
		r.fl = 1'b1;
		r.flags = {d[31], d == 32'h0, a >= b,
			(a[31] != b[31]) && (d[31] != a[31])};
		r.cyc = 5'h1;
		return r;
	endfunction : ef

	function automatic hrpl_res_type eb(input logic [31:0] t);
		hrpl_res_type r;
		r = '0;
		r.br = 1'b1;
		r.tgt = t & ~32'h1;
		r.nar = t[0];
		r.cyc = 5'h3;
		return r;
	endfunction : eb

	function automatic hrpl_res_type el(input logic [3:0] i,
		input logic [31:0] a);
		hrpl_res_type r;
		r = ew(i, a ^ 32'ha5a5_a5a5, 5'h3);
		r.ma = a;
		return r;
	endfunction : el

	task automatic results();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// offer one word, then gather every pulse until done or the bound
	task automatic run(input logic [15:0] ins, input logic [31:0] adr,
		output hrpl_res_type r);
		r = '0;
		@(negedge ref_clk);
		instr_valid = 1'b1;
		instr = ins;
		instr_addr = adr;
		chk("instr_ready", 32'h1, instr_ready);
		@(posedge ref_clk);
		@(negedge ref_clk);
		instr_valid = 1'b0;
		for (int n = 1; n < 24 && r.cyc == 5'h0; n++)
		begin
			if (n > 1)
				@(negedge ref_clk);
			r.wr |= wr_en;
			r.fl |= flags_we;
			r.br |= branch_valid;
			r.und |= undef_pulse;
			if (wr_en === 1'b1)
				{r.widx, r.wdata} = {wr_idx, wr_data};
			if (flags_we === 1'b1)
				r.flags = flags_out;
			if (branch_valid === 1'b1)
				{r.tgt, r.nar} = {branch_target, branch_narrow};
			if (mem_req === 1'b1)
				r.ma = mem_addr;
			if (done === 1'b1)
				r.cyc = n[4:0];
		end
		if (r.cyc == 5'h0)
		begin
			fail_count++;
			$display("[FAIL] done expected pulse seen none");
			results();
		end
	endtask : run

	task automatic cmp_res(input hrpl_res_type e, input hrpl_res_type s);
		chk("wr_en", e.wr, s.wr);
		chk("wr_idx", e.widx, s.widx);
		chk("wr_data", e.wdata, s.wdata);
		chk("flags_we", e.fl, s.fl);
		chk("flags_out", e.flags, s.flags);
		chk("branch_valid", e.br, s.br);
		chk("branch_target", e.tgt, s.tgt);
		chk("branch_narrow", e.nar, s.nar);
		chk("undef_pulse", e.und, s.und);
		chk("mem_addr", e.ma, s.ma);
		chk("cycles", e.cyc, s.cyc);
	endtask : cmp_res

	initial
	begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = 16'h0;
		instr_addr = 32'h0;
		current_status_flags = 4'ha;
		ack_wait = 4'h0;
		// ordinary cases: word, address, expected outcome
		rows.push_back('{16'h4449, adr0, ew(4'h1, rv(1) + rv(9), 5'h1)});
		rows.push_back('{16'h4492, adr0, ew(4'ha, rv(10) + rv(2), 5'h1)});
		rows.push_back('{16'h4564, adr0, ef(rv(4), rv(12))});
		rows.push_back('{16'h45e4, adr0, ef(rv(12), rv(12))});
		rows.push_back('{16'h4580, adr0, ef(rv(8), rv(0))});
		rows.push_back('{16'h4673, adr0, ew(4'h3, rv(14), 5'h1)});
		rows.push_back('{16'h468b, adr0, ew(4'hb, rv(1), 5'h1)});
		rows.push_back('{16'h46c9, adr0, ew(4'h9, rv(9), 5'h1)});
		rows.push_back('{16'h46fb, adr0, ew(4'hb, pcv, 5'h1)});
		rows.push_back('{16'h447a, adr0, ew(4'h2, rv(2) + pcv, 5'h1)});
		rows.push_back('{16'h46af, adr0, ew(4'hf, rv(5), 5'h3)});
		rows.push_back('{16'h44af, adr0, ew(4'hf, pcv + rv(5), 5'h3)});
		rows.push_back('{16'h4718, adr0, eb(rv(3))});
		rows.push_back('{16'h4750, adr0, eb(rv(10))});
		rows.push_back('{16'h4bd3, adr0, el(4'h3, lb(adr0) + 32'h34c)});
		rows.push_back('{16'h4fff, 32'h2000, el(4'h7, lb(32'h2000) + 32'h3fc)});
		rows.push_back('{16'h4800, 32'h2002, el(4'h0, lb(32'h2002))});
		// undefined high-flag combinations of add, compare, move, branch
		foreach (und_words[k])
			rows.push_back('{und_words[k], adr0,
				'{und: 1'b1, cyc: 5'h1, default: '0}});
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		foreach (rows[i])
		begin
			run(rows[i].ins, rows[i].adr, g);
			cmp_res(rows[i].e, g);
			$display("test %0d word %h done", i, rows[i].ins);
		end
		// back to back one-cycle adds, valid held high
		@(negedge ref_clk);
		instr_valid = 1'b1;
		instr = 16'h4449;
		@(negedge ref_clk);
		instr = 16'h4492;
		chk("wr_data", rv(1) + rv(9), wr_data);
		@(negedge ref_clk);
		instr_valid = 1'b0;
		chk("wr_idx", 32'ha, wr_idx);
		chk("wr_data", rv(10) + rv(2), wr_data);
		$display("test back_to_back done");
		// slow memory: each extra wait adds a cycle
		ack_wait = 4'h2;
		run(16'h4bd3, adr0, g);
		cmp_res('{wr: 1'b1, widx: 4'h3, wdata: (lb(adr0) + 32'h34c)
			^ 32'ha5a5_a5a5, ma: lb(adr0) + 32'h34c, cyc: 5'h5,
			default: '0}, g);
		$display("test slow_load done");
		// reset in mid-load abandons the request
		ack_wait = 4'hf;
		@(negedge ref_clk);
		instr_valid = 1'b1;
		instr = 16'h4fff;
		instr_addr = 32'h2000;
		@(negedge ref_clk);
		instr_valid = 1'b0;
		chk("instr_ready", 32'h0, instr_ready);
		chk("mem_addr", 32'h2400, mem_addr);
		rst = 1'b1;
		@(negedge ref_clk);
		rst = 1'b0;
		chk("mem_req", 32'h0, mem_req);
		chk("instr_ready", 32'h1, instr_ready);
		chk("done", 32'h0, {wr_en, done, flags_out});
		$display("test mid_reset done");
		ack_wait = 4'h0;
		results();
	end
endmodule : tb_hrpl_exec
